// ### common/led_flash_pkg.sv
// Shared constants for the single-wire LED flash command receiver.
package led_flash_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS         = 8;      // 125 MHz system clock.
  localparam int CNT_W                 = 17;     // Wide enough for the long-low reset time.
  localparam int START_HIGH_TIME_US    = 10;     // Least high time before the first bit.
  localparam int END_HIGH_TIME_US      = 350;    // High time that closes a byte.
  localparam int LONG_LOW_RESET_TIME_US = 700;   // Low time that resets the block.

  // Least times round up to whole cycles.
  localparam logic [CNT_W-1:0] START_HIGH_CYCLES =
    CNT_W'((START_HIGH_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] END_HIGH_CYCLES =
    CNT_W'((END_HIGH_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] LONG_LOW_RESET_CYCLES =
    CNT_W'((LONG_LOW_RESET_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================================
  // Command byte layout
  // ==========================================================================
  localparam int          ADDR_MSB   = 7;       // Register select, top of byte.
  localparam int          ADDR_LSB   = 5;       // Register select, bottom.
  localparam int          DATA_MSB   = 4;       // Data value, top.
  localparam int          DATA_W     = 5;       // Data value width.
  localparam int          NUM_REGS   = 6;       // Defined register codes.
  localparam logic [3:0]  BYTE_BITS  = 4'h8;    // Bits in one command.
  localparam logic [3:0]  BIT_CNT_ONE = 4'h1;   // Bit counter step.

  // ==========================================================================
  // Register select codes
  // ==========================================================================
  localparam logic [2:0] ADDR_LOW_INPUT  = 3'h0;
  localparam logic [2:0] ADDR_TIMEOUT    = 3'h1;
  localparam logic [2:0] ADDR_TIMER_MIN  = 3'h2;
  localparam logic [2:0] ADDR_MOVIE_CUR  = 3'h3;
  localparam logic [2:0] ADDR_FLASH_CUR  = 3'h4;
  localparam logic [2:0] ADDR_MODE_CTRL  = 3'h5;

  // ==========================================================================
  // Mode field and defaults
  // ==========================================================================
  localparam logic [1:0]        MODE_OFF   = 2'h0;
  localparam logic [1:0]        MODE_MOVIE = 2'h1;
  localparam logic [1:0]        MODE_FLASH = 2'h2;
  localparam logic [DATA_W-1:0] MODE_FLASH_VALUE    = 5'h02;
  localparam logic [DATA_W-1:0] GUARD_DISABLED_CODE = 5'h00;

  // Reset values, indexed by register select code.
  localparam logic [DATA_W-1:0] DEF_LOW_INPUT = 5'h00;
  localparam logic [DATA_W-1:0] DEF_TIMEOUT   = 5'h00;
  localparam logic [DATA_W-1:0] DEF_TIMER_MIN = 5'h00;
  localparam logic [DATA_W-1:0] DEF_MOVIE_CUR = 5'h05;
  localparam logic [DATA_W-1:0] DEF_FLASH_CUR = 5'h0F;
  localparam logic [DATA_W-1:0] DEF_MODE_CTRL = 5'h00;
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_DEFAULTS =
    {DEF_MODE_CTRL, DEF_FLASH_CUR, DEF_MOVIE_CUR, DEF_TIMER_MIN, DEF_TIMEOUT, DEF_LOW_INPUT};

endpackage

// ### verilog/duration_timer.sv
// Saturating counter of cycles since the last restart.
`timescale 1ns/1ps

module duration_timer #(
  parameter int W = 17
) (
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         reset_n,
  // Control.
  input  wire logic         restart,
  // Elapsed cycles.
  output logic [W-1:0]      count_q
);

  typedef struct packed {
    logic [W-1:0] count;    // Cycles since restart.
  } timer_s;

  timer_s s_q;              // Registered state.
  timer_s s_d;              // Next state.

  // ==========================================================================
  // Counting
  // ==========================================================================
  // Saturation keeps a very long level from wrapping and looking short again.
  always_comb
  begin
    s_d = s_q;
    if (restart)
    begin
      s_d.count = '0;
    end
    else if (s_q.count != {W{1'b1}})
    begin
      s_d.count = W'(s_q.count + 1'b1);
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign count_q = s_q.count;

endmodule

// ### verilog/setting_reg.sv
// One write-only 5-bit setting with a clear back to its default.
`timescale 1ns/1ps

module setting_reg #(
  parameter logic [4:0] DEFAULT = 5'h00
) (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Update controls; clear has priority over load.
  input  wire logic       clear,
  input  wire logic       load,
  input  wire logic [4:0] load_value,
  // Stored value.
  output logic [4:0]      value_q
);

  typedef struct packed {
    logic [4:0] value;      // Current setting.
  } setting_s;

  setting_s s_q;            // Registered state.
  setting_s s_d;            // Next state.

  // ==========================================================================
  // Update
  // ==========================================================================
  // A protection clear must never be undone by a write in the same cycle.
  always_comb
  begin
    s_d = s_q;
    if (clear)
    begin
      s_d.value = DEFAULT;
    end
    else if (load)
    begin
      s_d.value = load_value;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q.value <= DEFAULT;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign value_q = s_q.value;

endmodule

// ### verilog/single_wire_led_flash_ctrl.sv
// Single-wire command receiver and mode control for an LED flash driver.
`timescale 1ns/1ps

module single_wire_led_flash_ctrl #(
  parameter logic [16:0] END_HIGH_CYCLES       = led_flash_pkg::END_HIGH_CYCLES,
  parameter logic [16:0] LONG_LOW_RESET_CYCLES = led_flash_pkg::LONG_LOW_RESET_CYCLES
) (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Host link and trigger.
  input  wire logic       ctrl_pin,
  input  wire logic       aux_trigger,
  // Analog comparator results.
  input  wire logic       low_input_below,
  input  wire logic       led_short_detect,
  input  wire logic       overvoltage_limit,
  input  wire logic       over_temp,
  // Stored settings.
  output logic [4:0]      low_input_threshold_q,
  output logic [4:0]      flash_timeout_q,
  output logic [4:0]      timer_min_current_q,
  output logic [4:0]      movie_current_level_q,
  output logic [4:0]      flash_current_level_q,
  output logic [4:0]      led_mode_control_q,
  // Drive controls for the analog stage.
  output logic            movie_drive_q,
  output logic            flash_drive_q,
  output logic            sense_current_q,
  output logic            thermal_reduce_q,
  output logic            low_input_guard_q
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  typedef enum logic [1:0] {WAIT_START, ARMED, LOW_PHASE, HIGH_PHASE} link_e;

  typedef struct packed {
    link_e                          st;           // Link decoder state.
    logic                           ctrl_prev;    // Pin level one cycle ago.
    logic                           aux_prev;     // Trigger level one cycle ago.
    logic [led_flash_pkg::CNT_W-1:0] low_len;     // Length of last low phase.
    logic [7:0]                     shift;        // Received bits.
    logic [3:0]                     bit_cnt;      // Bits received in this byte.
    logic                           overflow;     // More than eight bits seen.
    logic                           movie_drive;  // Movie current enable.
    logic                           flash_drive;  // Flash current enable.
    logic                           sense;        // Short-sense current enable.
    logic                           thermal;      // Thermal fold-back request.
    logic                           guard;        // Low-input guard armed.
  } ctrl_s;

  ctrl_s s_q;                                          // Registered state.
  ctrl_s s_d;                                          // Next state.
  logic [led_flash_pkg::CNT_W-1:0]        level_cnt;   // Cycles at the current pin level.
  logic                                   pin_edge;    // Pin changed this cycle.
  logic                                   soft_reset;  // Long-low reset pulse.
  logic                                   commit;      // Byte complete with eight bits.
  logic [2:0]                             cmd_addr;    // Select field of the byte.
  logic [4:0]                             cmd_data;    // Data field of the byte.
  logic                                   guard_trip;  // Input below the armed threshold.
  logic                                   mode_clear;  // Mode register back to default.
  logic                                   aux_rise;    // Trigger rising edge.
  logic [1:0]                             mode_bits;   // Current mode field.
  logic [led_flash_pkg::NUM_REGS-1:0]            reg_clear;  // Per-register clear.
  logic [led_flash_pkg::NUM_REGS-1:0]            reg_load;   // Per-register load.
  logic [led_flash_pkg::NUM_REGS-1:0][4:0]       reg_value;  // Per-register load value.
  logic [led_flash_pkg::NUM_REGS-1:0][4:0]       reg_q;      // Per-register contents.

  // ==========================================================================
  // Pulse timing
  // ==========================================================================
  // One timer measures each level; it restarts on every pin edge.
  assign pin_edge = ctrl_pin ^ s_q.ctrl_prev;

  duration_timer #(
    .W (led_flash_pkg::CNT_W)
  ) u_level_timer (
    .mclk    (mclk),
    .reset_n (reset_n),
    .restart (pin_edge),
    .count_q (level_cnt)
  );

  // A pin held low long enough wipes every setting, whatever the decoder was doing.
  assign soft_reset = !ctrl_pin && !pin_edge && (level_cnt == LONG_LOW_RESET_CYCLES);

  // The byte is taken only once the closing high has lasted long enough.
  assign commit   = (s_q.st == HIGH_PHASE) && ctrl_pin && (level_cnt == END_HIGH_CYCLES)
                    && (s_q.bit_cnt == led_flash_pkg::BYTE_BITS) && !s_q.overflow;
  assign cmd_addr = s_q.shift[led_flash_pkg::ADDR_MSB:led_flash_pkg::ADDR_LSB];
  assign cmd_data = s_q.shift[led_flash_pkg::DATA_MSB:0];

  // ==========================================================================
  // Protection and mode control
  // ==========================================================================
  // Threshold code zero leaves the guard disarmed, so it can never trip.
  assign guard_trip = low_input_below
                      && (low_input_threshold_q != led_flash_pkg::GUARD_DISABLED_CODE);
  assign mode_clear = soft_reset || guard_trip || overvoltage_limit;
  assign aux_rise   = aux_trigger && !s_q.aux_prev;
  assign mode_bits  = led_mode_control_q[1:0];

  // Write strobes for the six settings; an unknown select code loads nothing.
  always_comb
  begin
    for (int i = 0; i < led_flash_pkg::NUM_REGS; i++)
    begin
      reg_clear[i] = soft_reset;
      reg_load[i]  = commit && (cmd_addr == 3'(i));
      reg_value[i] = cmd_data;
    end
    // The trigger wins over a command write of the mode field; a mode clear still beats both.
    reg_clear[led_flash_pkg::ADDR_MODE_CTRL] = mode_clear;
    reg_load[led_flash_pkg::ADDR_MODE_CTRL]  = aux_rise
      || (commit && (cmd_addr == led_flash_pkg::ADDR_MODE_CTRL));
    reg_value[led_flash_pkg::ADDR_MODE_CTRL] = aux_rise ? led_flash_pkg::MODE_FLASH_VALUE : cmd_data;
  end

  // ==========================================================================
  // Settings registers
  // ==========================================================================
  for (genvar g = 0; g < led_flash_pkg::NUM_REGS; g++)
  begin : g_reg
    setting_reg #(
      .DEFAULT (led_flash_pkg::REG_DEFAULTS[g])
    ) u_setting (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .clear      (reg_clear[g]),
      .load       (reg_load[g]),
      .load_value (reg_value[g]),
      .value_q    (reg_q[g])
    );
  end

  assign low_input_threshold_q = reg_q[led_flash_pkg::ADDR_LOW_INPUT];
  assign flash_timeout_q       = reg_q[led_flash_pkg::ADDR_TIMEOUT];
  assign timer_min_current_q   = reg_q[led_flash_pkg::ADDR_TIMER_MIN];
  assign movie_current_level_q = reg_q[led_flash_pkg::ADDR_MOVIE_CUR];
  assign flash_current_level_q = reg_q[led_flash_pkg::ADDR_FLASH_CUR];
  assign led_mode_control_q    = reg_q[led_flash_pkg::ADDR_MODE_CTRL];

  // ==========================================================================
  // Link decoder and drive outputs
  // ==========================================================================
  // Each bit is a low phase then a high phase; the longer one gives its value.
  always_comb
  begin
    s_d           = s_q;
    s_d.ctrl_prev = ctrl_pin;
    s_d.aux_prev  = aux_trigger;
    case (s_q.st)
      // Wait for a high that is long enough to open a byte.
      WAIT_START:
      begin
        if (ctrl_pin && !pin_edge && (level_cnt >= led_flash_pkg::START_HIGH_CYCLES))
        begin
          s_d.st       = ARMED;
          s_d.bit_cnt  = '0;
          s_d.overflow = 1'b0;
        end
      end
      // Line idles high; the first fall starts a bit.
      ARMED:
      begin
        if (!ctrl_pin)
        begin
          s_d.st = LOW_PHASE;
        end
      end
      // Remember how long the low lasted.
      LOW_PHASE:
      begin
        if (ctrl_pin)
        begin
          s_d.low_len = level_cnt;
          s_d.st      = HIGH_PHASE;
        end
      end
      // A fall closes the bit; a long high closes the byte.
      HIGH_PHASE:
      begin
        if (!ctrl_pin)
        begin
          s_d.st = LOW_PHASE;
          if (s_q.bit_cnt == led_flash_pkg::BYTE_BITS)
          begin
            s_d.overflow = 1'b1;
          end
          else
          begin
            s_d.shift   = {s_q.shift[6:0], (level_cnt > s_q.low_len)};
            s_d.bit_cnt = 4'(s_q.bit_cnt + led_flash_pkg::BIT_CNT_ONE);
          end
        end
        else if (level_cnt == END_HIGH_CYCLES)
        begin
          // Short or long bytes are dropped here without touching any setting.
          s_d.st       = ARMED;
          s_d.bit_cnt  = '0;
          s_d.overflow = 1'b0;
        end
      end
      default:
      begin
        s_d.st = WAIT_START;
      end
    endcase
    if (soft_reset)
    begin
      s_d.st = WAIT_START;
    end
    // Drives follow the mode field; a short only withholds current for as long as it lasts.
    s_d.sense       = (mode_bits != led_flash_pkg::MODE_OFF) && !guard_trip;
    s_d.movie_drive = (mode_bits == led_flash_pkg::MODE_MOVIE) && !led_short_detect && !guard_trip;
    s_d.flash_drive = (mode_bits == led_flash_pkg::MODE_FLASH) && !led_short_detect && !guard_trip;
    s_d.thermal     = (s_q.movie_drive || s_q.flash_drive) && over_temp;
    s_d.guard       = low_input_threshold_q != led_flash_pkg::GUARD_DISABLED_CODE;
  end

  // State register; the pin idles high, so its history resets high.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q           <= '0;
      s_q.st        <= WAIT_START;
      s_q.ctrl_prev <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign movie_drive_q     = s_q.movie_drive;
  assign flash_drive_q     = s_q.flash_drive;
  assign sense_current_q   = s_q.sense;
  assign thermal_reduce_q  = s_q.thermal;
  assign low_input_guard_q = s_q.guard;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  mode_decode_a: assert property (
    (mode_bits == led_flash_pkg::MODE_MOVIE) && !led_short_detect && !guard_trip
    |=> movie_drive_q && !flash_drive_q) else $error("movie mode not driven");
  flash_decode_a: assert property (
    (mode_bits == led_flash_pkg::MODE_FLASH) && !led_short_detect && !guard_trip
    |=> flash_drive_q && !movie_drive_q) else $error("flash mode not driven");
  mode_idle_a: assert property (
    (mode_bits != led_flash_pkg::MODE_MOVIE) && (mode_bits != led_flash_pkg::MODE_FLASH)
    |=> !movie_drive_q && !flash_drive_q) else $error("idle mode drove current");
  long_low_reset_a: assert property (
    soft_reset |=> (led_mode_control_q == led_flash_pkg::DEF_MODE_CTRL)
    && (movie_current_level_q == led_flash_pkg::DEF_MOVIE_CUR)
    && (flash_current_level_q == led_flash_pkg::DEF_FLASH_CUR)) else $error("long low did not reset");
  aux_flash_a: assert property (
    aux_rise && !mode_clear
    |=> (mode_bits == led_flash_pkg::MODE_FLASH)) else $error("trigger did not set flash");
  guard_trip_a: assert property (
    guard_trip |=> (led_mode_control_q == led_flash_pkg::DEF_MODE_CTRL)
    && !movie_drive_q && !flash_drive_q) else $error("low input did not cut current");
  guard_off_a: assert property (
    (low_input_threshold_q == led_flash_pkg::GUARD_DISABLED_CODE)
    |-> !guard_trip ##1 !low_input_guard_q) else $error("disabled guard armed");
  short_cut_a: assert property (
    led_short_detect && (mode_bits != led_flash_pkg::MODE_OFF) && !guard_trip
    |=> !movie_drive_q && !flash_drive_q && sense_current_q) else $error("short not handled");
  short_recover_a: assert property (
    $fell(led_short_detect) && !guard_trip
    |=> (movie_drive_q == ($past(mode_bits) == led_flash_pkg::MODE_MOVIE))
    && (flash_drive_q == ($past(mode_bits) == led_flash_pkg::MODE_FLASH)))
    else $error("no recovery after short");
  open_led_a: assert property (
    overvoltage_limit |=> (led_mode_control_q == led_flash_pkg::DEF_MODE_CTRL)
    ##1 !movie_drive_q && !flash_drive_q) else $error("overvoltage did not clear mode");
  byte_commit_a: assert property (
    commit && (cmd_addr == led_flash_pkg::ADDR_FLASH_CUR) && !soft_reset
    |=> flash_current_level_q == $past(cmd_data)) else $error("flash level not written");
  bad_select_a: assert property (
    commit && (cmd_addr > led_flash_pkg::ADDR_MODE_CTRL) && !soft_reset
    |=> $stable({low_input_threshold_q, flash_timeout_q, timer_min_current_q, movie_current_level_q,
    flash_current_level_q})) else $error("undefined select changed a setting");
  thermal_fold_a: assert property (
    (movie_drive_q || flash_drive_q) && over_temp |=> thermal_reduce_q)
    else $error("no thermal fold-back");

endmodule

// ### verification/host_wire_model.sv
// Host model that drives the single-wire command pin.
`timescale 1ns/1ps

module host_wire_model #(
  parameter int END_CYC = 200
) (
  // Clock.
  input  wire logic mclk,
  // Command pin; it idles high like a pulled-up line.
  output logic      ctrl_pin
);
  // Short bit phase; long phases are twice it, well below the closing high.
  localparam int SHORT_CYC = 20;

  initial ctrl_pin = 1'b1;

  // ==========================================================================
  // Pin phases
  // ==========================================================================
  // Hold one level for n cycles; the level changes just after a clock edge.
  task automatic ph(input logic v, input int n);
    ctrl_pin = v;
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Send one whole byte, most significant bit first, framed by start and end.
  task automatic send(input logic [7:0] b);
    ph(1'b1, 1300);
    for (int i = 7; i >= 0; i--)
    begin
      ph(1'b0, b[i] ? SHORT_CYC : 2 * SHORT_CYC);
      ph(1'b1, b[i] ? 2 * SHORT_CYC : SHORT_CYC);
    end
    ph(1'b0, SHORT_CYC);
    ph(1'b1, END_CYC + 10);
  endtask

  // Hold the pin low long enough to clear every setting.
  task automatic long_low(input int n);
    ph(1'b0, n);
    ph(1'b1, 10);
  endtask
endmodule

// ### verification/tb.sv
// Self-checking testbench for the single-wire LED flash receiver.
`timescale 1ns/1ps

module tb;
  // Shortened counts keep the run brief; bit phases stay far below both.
  localparam int END_CYC = 200;
  localparam int RST_CYC = 400;

  logic            mclk;
  logic            reset_n;
  logic            ctrl_pin;
  logic            aux_trigger;
  logic            low_input_below;
  logic            led_short_detect;
  logic            overvoltage_limit;
  logic            over_temp;
  wire  [5:0][4:0] got_regs;
  logic [5:0][4:0] exp_regs;
  logic            movie_drive_q;
  logic            flash_drive_q;
  logic            sense_current_q;
  logic            thermal_reduce_q;
  logic            low_input_guard_q;
  int              err_total;
  int              n_checks;
  int              seed;

  // ==========================================================================
  // Design, host and clock
  // ==========================================================================
  single_wire_led_flash_ctrl #(.END_HIGH_CYCLES(17'(END_CYC)), .LONG_LOW_RESET_CYCLES(17'(RST_CYC))) dut (
    .mclk(mclk), .reset_n(reset_n), .ctrl_pin(ctrl_pin), .aux_trigger(aux_trigger),
    .low_input_below(low_input_below), .led_short_detect(led_short_detect),
    .overvoltage_limit(overvoltage_limit), .over_temp(over_temp),
    .low_input_threshold_q(got_regs[0]), .flash_timeout_q(got_regs[1]), .timer_min_current_q(got_regs[2]),
    .movie_current_level_q(got_regs[3]), .flash_current_level_q(got_regs[4]), .led_mode_control_q(got_regs[5]),
    .movie_drive_q(movie_drive_q), .flash_drive_q(flash_drive_q), .sense_current_q(sense_current_q),
    .thermal_reduce_q(thermal_reduce_q), .low_input_guard_q(low_input_guard_q));

  host_wire_model #(.END_CYC(END_CYC)) host (.mclk(mclk), .ctrl_pin(ctrl_pin));

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Expected drive pair {flash, movie} for a mode field; code 11 drives nothing.
  function automatic logic [4:0] drives(input logic [1:0] m);
    return {3'h0, m == led_flash_pkg::MODE_FLASH, m == led_flash_pkg::MODE_MOVIE};
  endfunction

  // Let n edges pass, then step just past the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Compare one value and count it.
  task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  // Compare all six settings.
  task automatic chk_regs();
    for (int i = 0; i < 6; i++)
    begin
      chk($sformatf("setting %0d", i), exp_regs[i], got_regs[i]);
    end
  endtask

  // Send one command; only defined select codes change the expectation.
  task automatic wr(input logic [2:0] a, input logic [4:0] d);
    host.send({a, d});
    if (a < 3'h6)
    begin
      exp_regs[a] = d;
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    seed = 32'h2E1D9881;
    err_total = 0;
    n_checks = 0;
    {reset_n, aux_trigger, low_input_below, led_short_detect, overvoltage_limit, over_temp} = 6'h00;
    exp_regs = led_flash_pkg::REG_DEFAULTS;
    cyc(10);
    reset_n = 1'b1;
    chk_regs();
    $display("test reset done");
    for (int a = 0; a < 5; a++)
    begin
      wr(3'(a), 5'($random(seed)));
    end
    chk_regs();
    wr(3'h6, 5'($random(seed)));
    wr(3'h7, 5'($random(seed)));
    chk_regs();
    $display("test writes done");
    for (int m = 0; m < 4; m++)
    begin
      wr(led_flash_pkg::ADDR_MODE_CTRL, 5'(m));
      chk_regs();
      chk("drives", drives(2'(m)), {3'h0, flash_drive_q, movie_drive_q});
    end
    $display("test modes done");
    wr(led_flash_pkg::ADDR_MODE_CTRL, 5'h00);
    aux_trigger = 1'b1;
    cyc(3);
    exp_regs[5] = led_flash_pkg::MODE_FLASH_VALUE;
    chk("aux mode", exp_regs[5], got_regs[5]);
    chk("aux drives", drives(2'h2), {3'h0, flash_drive_q, movie_drive_q});
    aux_trigger = 1'b0;
    $display("test aux done");
    wr(3'h0, 5'h01);
    wr(3'h5, 5'h01);
    chk("guard armed", 5'h01, {4'h0, low_input_guard_q});
    low_input_below = 1'b1;
    cyc(3);
    chk("guard mode", 5'h00, got_regs[5]);
    chk("guard drives", 5'h00, {3'h0, flash_drive_q, movie_drive_q});
    low_input_below = 1'b0;
    wr(3'h0, 5'h00);
    wr(3'h5, 5'h01);
    low_input_below = 1'b1;
    cyc(3);
    chk("guard off mode", 5'h01, got_regs[5]);
    chk("guard off", 5'h00, {4'h0, low_input_guard_q});
    low_input_below = 1'b0;
    $display("test low input done");
    led_short_detect = 1'b1;
    cyc(3);
    chk("short drives", 5'h00, {3'h0, flash_drive_q, movie_drive_q});
    chk("short sense", 5'h01, {4'h0, sense_current_q});
    led_short_detect = 1'b0;
    cyc(3);
    chk("short gone", drives(2'h1), {3'h0, flash_drive_q, movie_drive_q});
    over_temp = 1'b1;
    cyc(3);
    chk("fold back", 5'h01, {4'h0, thermal_reduce_q});
    over_temp = 1'b0;
    overvoltage_limit = 1'b1;
    cyc(3);
    chk("open mode", 5'h00, got_regs[5]);
    overvoltage_limit = 1'b0;
    $display("test faults done");
    wr(3'h4, 5'($random(seed)));
    host.long_low(RST_CYC + 10);
    exp_regs = led_flash_pkg::REG_DEFAULTS;
    chk_regs();
    $display("test long low done");
    test_done();
  end
endmodule
